// *** logic/adc_ref_cal_gain_regs.sv ***
// Reference, calibration and amplifier registers with calibration datapath
// Behaviour
// - Positive reference code routes supply, pin, input0
// - Negative reference code routes ground, pin, input1
// - Reference register at 06h resets to 05h
// - Offset word in 07h-09h, low byte first
// - Offset word is signed two's complement
// - Offset subtracted before full-scale scaling
// - Full-scale word is unsigned straight binary
// - Result scaled by full-scale over 400000h
// - Full-scale word 0Ah-0Ch resets to 400000h
// - 0Eh and 0Fh read-only, read zero
// - 0Dh read-only, chosen read value zero
// - Amplifier bit 7 selects bypass when set
// - Amplifier at 10h, gain 1/64/128 codes
`include "cal_regs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_ref_cal_gain_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic raw_valid,
  input wire logic [23:0] raw_sample,
  output logic cal_valid,
  output logic [23:0] cal_result,
  output cal_regs_pkg::ref_route_t ref_route,
  output cal_regs_pkg::amp_route_t amp_route
);

  logic [7:0] reference_select;
  logic [23:0] offset_word;
  logic [23:0] fullscale_word;
  logic [7:0] amplifier_config;
  logic [23:0] sw_raw;
  logic sw_start;

  cal_regs_pkg::ahb_addr_t addr_in;
  logic wr_pending;
  logic [4:0] wr_index;
  logic take;
  logic [4:0] addr_index;
  logic addr_in_range;

  assign addr_in.haddr = haddr;
  assign addr_in.htrans = htrans;
  assign addr_in.hwrite = hwrite;
  assign addr_in.hsize = hsize;

  // Zero-wait slave; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && hready && addr_in.htrans[1];
  assign addr_in_range = (addr_in.haddr[31:7] == 25'h0000000);
  assign addr_index = addr_in.haddr[6:2];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pending <= 1'b0;
      wr_index <= 5'h00;
    end else begin
      wr_pending <= take && addr_in.hwrite && addr_in_range;
      wr_index <= addr_index;
    end
  end

  logic busy;
  logic [31:0] next_hrdata;

  // Read word chosen in the address phase so it stands in the data phase
  always_comb begin
    next_hrdata = 32'h00000000;
    if (addr_in_range) begin
      case (addr_index)
        `IDX_REFERENCE_SELECT: begin
          next_hrdata = {24'h000000, reference_select};
        end
        `IDX_OFFSET_CAL_BYTE0: begin
          next_hrdata = {24'h000000, offset_word[7:0]};
        end
        `IDX_OFFSET_CAL_BYTE1: begin
          next_hrdata = {24'h000000, offset_word[15:8]};
        end
        `IDX_OFFSET_CAL_BYTE2: begin
          next_hrdata = {24'h000000, offset_word[23:16]};
        end
        `IDX_FULLSCALE_CAL_BYTE0: begin
          next_hrdata = {24'h000000, fullscale_word[7:0]};
        end
        `IDX_FULLSCALE_CAL_BYTE1: begin
          next_hrdata = {24'h000000, fullscale_word[15:8]};
        end
        `IDX_FULLSCALE_CAL_BYTE2: begin
          next_hrdata = {24'h000000, fullscale_word[23:16]};
        end
        `IDX_SPARE_LOCATION_A: begin
          next_hrdata = {24'h000000, `SPARE_A_VALUE};
        end
        `IDX_SPARE_LOCATION_B: begin
          next_hrdata = {24'h000000, `SPARE_BC_VALUE};
        end
        `IDX_SPARE_LOCATION_C: begin
          next_hrdata = {24'h000000, `SPARE_BC_VALUE};
        end
        `IDX_AMPLIFIER_CONFIG: begin
          next_hrdata = {24'h000000, amplifier_config};
        end
        `IDX_RAW_SAMPLE: begin
          next_hrdata = {8'h00, sw_raw};
        end
        `IDX_CAL_RESULT: begin
          next_hrdata = {8'h00, cal_result};
        end
        `IDX_CAL_STATUS: begin
          next_hrdata = {31'h0, busy};
        end
        default: begin
          next_hrdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (take && !addr_in.hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Reserved high bits are stored as written; host keeps them zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reference_select <= `RST_REFERENCE_SELECT;
      offset_word <= {3{`RST_OFFSET_BYTE}};
      fullscale_word <= {`RST_FULLSCALE_BYTE2, `RST_FULLSCALE_BYTE1,
                         `RST_FULLSCALE_BYTE0};
      amplifier_config <= `RST_AMPLIFIER_CONFIG;
      sw_raw <= 24'h000000;
    end else if (wr_pending) begin
      case (wr_index)
        `IDX_REFERENCE_SELECT: begin
          reference_select <= hwdata[7:0];
        end
        `IDX_OFFSET_CAL_BYTE0: begin
          offset_word[7:0] <= hwdata[7:0];
        end
        `IDX_OFFSET_CAL_BYTE1: begin
          offset_word[15:8] <= hwdata[7:0];
        end
        `IDX_OFFSET_CAL_BYTE2: begin
          offset_word[23:16] <= hwdata[7:0];
        end
        `IDX_FULLSCALE_CAL_BYTE0: begin
          fullscale_word[7:0] <= hwdata[7:0];
        end
        `IDX_FULLSCALE_CAL_BYTE1: begin
          fullscale_word[15:8] <= hwdata[7:0];
        end
        `IDX_FULLSCALE_CAL_BYTE2: begin
          fullscale_word[23:16] <= hwdata[7:0];
        end
        `IDX_AMPLIFIER_CONFIG: begin
          amplifier_config <= hwdata[7:0];
        end
        `IDX_RAW_SAMPLE: begin
          sw_raw <= hwdata[23:0];
        end
        default: begin
          // Spare, result and status locations ignore writes
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_start <= 1'b0;
    end else begin
      sw_start <= wr_pending && (wr_index == `IDX_RAW_SAMPLE);
    end
  end

  // Reference routing; reserved code drives no path
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_route <= '0;
    end else begin
      ref_route.analog_supply <=
        reference_select[`REF_POS_MSB:`REF_POS_LSB] ==
        cal_regs_pkg::ref_pos_analog_supply;
      ref_route.ref_pin_pos_first <=
        reference_select[`REF_POS_MSB:`REF_POS_LSB] ==
        cal_regs_pkg::ref_pos_pin_first;
      ref_route.analog_input_zero <=
        reference_select[`REF_POS_MSB:`REF_POS_LSB] ==
        cal_regs_pkg::ref_pos_analog_input_zero;
      ref_route.analog_ground <=
        reference_select[`REF_NEG_MSB:`REF_NEG_LSB] ==
        cal_regs_pkg::ref_neg_analog_ground;
      ref_route.ref_pin_neg_first <=
        reference_select[`REF_NEG_MSB:`REF_NEG_LSB] ==
        cal_regs_pkg::ref_neg_pin_first;
      ref_route.analog_input_one <=
        reference_select[`REF_NEG_MSB:`REF_NEG_LSB] ==
        cal_regs_pkg::ref_neg_analog_input_one;
    end
  end

  // Amplifier routing; reserved gain codes select no gain
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      amp_route <= '0;
    end else begin
      amp_route.bypass <= amplifier_config[`AMP_BYPASS_BIT];
      amp_route.gain_1 <=
        amplifier_config[`AMP_GAIN_MSB:`AMP_GAIN_LSB] == 3'b000;
      amp_route.gain_64 <=
        amplifier_config[`AMP_GAIN_MSB:`AMP_GAIN_LSB] == 3'b110;
      amp_route.gain_128 <=
        amplifier_config[`AMP_GAIN_MSB:`AMP_GAIN_LSB] == 3'b111;
    end
  end

  // Two-stage pipeline: subtract, then multiply and shift with saturation.
  // A pin sample wins over a software sample arriving the same cycle.
  logic stage1_valid;
  logic signed [24:0] diff;
  logic signed [49:0] product;
  logic signed [49:0] scaled;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_valid <= 1'b0;
      diff <= '0;
    end else begin
      stage1_valid <= raw_valid || sw_start;
      if (raw_valid) begin
        diff <= $signed({raw_sample[23], raw_sample}) -
                $signed({offset_word[23], offset_word});
      end else if (sw_start) begin
        diff <= $signed({sw_raw[23], sw_raw}) -
                $signed({offset_word[23], offset_word});
      end
    end
  end

  // Zero-extend the full-scale word so it multiplies as unsigned
  assign product = diff * $signed({1'b0, fullscale_word});
  assign scaled = product >>> `FULLSCALE_SHIFT;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_valid <= 1'b0;
      cal_result <= 24'h000000;
    end else begin
      cal_valid <= stage1_valid;
      if (stage1_valid) begin
        if (scaled > $signed(50'sh7FFFFF)) begin
          cal_result <= `RESULT_MAX;
        end else if (scaled < -$signed(50'sh800000)) begin
          cal_result <= `RESULT_MIN;
        end else begin
          cal_result <= scaled[23:0];
        end
      end
    end
  end

  assign busy = stage1_valid || sw_start;

endmodule

`default_nettype wire

// *** logic/cal_regs_cfg.svh ***
// Register map, reset values, field positions and calibration constants
`ifndef CAL_REGS_CFG_SVH
`define CAL_REGS_CFG_SVH

// Printed offsets are register indices; byte address is four times index
`define IDX_REFERENCE_SELECT 5'h06
`define IDX_OFFSET_CAL_BYTE0 5'h07
`define IDX_OFFSET_CAL_BYTE1 5'h08
`define IDX_OFFSET_CAL_BYTE2 5'h09
`define IDX_FULLSCALE_CAL_BYTE0 5'h0A
`define IDX_FULLSCALE_CAL_BYTE1 5'h0B
`define IDX_FULLSCALE_CAL_BYTE2 5'h0C
`define IDX_SPARE_LOCATION_A 5'h0D
`define IDX_SPARE_LOCATION_B 5'h0E
`define IDX_SPARE_LOCATION_C 5'h0F
`define IDX_AMPLIFIER_CONFIG 5'h10
// Own registers: raw sample in, corrected result and busy status out
`define IDX_RAW_SAMPLE 5'h14
`define IDX_CAL_RESULT 5'h15
`define IDX_CAL_STATUS 5'h16

`define RST_REFERENCE_SELECT 8'h05
`define RST_OFFSET_BYTE 8'h00
`define RST_FULLSCALE_BYTE0 8'h00
`define RST_FULLSCALE_BYTE1 8'h00
`define RST_FULLSCALE_BYTE2 8'h40
`define RST_AMPLIFIER_CONFIG 8'h00
`define SPARE_A_VALUE 8'h00
`define SPARE_BC_VALUE 8'h00

`define REF_POS_MSB 3
`define REF_POS_LSB 2
`define REF_NEG_MSB 1
`define REF_NEG_LSB 0
`define AMP_BYPASS_BIT 7
`define AMP_GAIN_MSB 2
`define AMP_GAIN_LSB 0

// Unity full-scale word is 2^22, so scaling is a right shift by 22
`define FULLSCALE_SHIFT 22
`define RESULT_MAX 24'h7FFFFF
`define RESULT_MIN 24'h800000

`endif

// *** logic/cal_regs_pkg.sv ***
// Types shared by the calibration register bank
package cal_regs_pkg;

  typedef enum logic [1:0] {
    ref_pos_reserved, ref_pos_analog_supply, ref_pos_pin_first,
    ref_pos_analog_input_zero
  } ref_pos_select_t;

  typedef enum logic [1:0] {
    ref_neg_reserved, ref_neg_analog_ground, ref_neg_pin_first,
    ref_neg_analog_input_one
  } ref_neg_select_t;

  typedef struct packed {
    logic analog_supply;
    logic ref_pin_pos_first;
    logic analog_input_zero;
    logic analog_ground;
    logic ref_pin_neg_first;
    logic analog_input_one;
  } ref_route_t;

  typedef struct packed {
    logic bypass;
    logic gain_1;
    logic gain_64;
    logic gain_128;
  } amp_route_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
  } ahb_addr_t;

endpackage

// *** tb/adc_ref_cal_gain_regs_assertions.sv ***
// Port checker for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_ref_cal_gain_regs_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic raw_valid,
  input wire logic cal_valid,
  input wire logic [23:0] cal_result,
  input wire cal_regs_pkg::ref_route_t ref_route,
  input wire cal_regs_pkg::amp_route_t amp_route
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rd_spare;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_spare <= 1'b0;
    end else begin
      rd_spare <= hsel && hready && htrans[1] && !hwrite &&
        haddr >= 32'h34 && haddr <= 32'h3C;
    end
  end
  sequence raw_in; raw_valid; endsequence
  sequence spare_rd; rd_spare; endsequence
  AST_POS_ONE: assert property ($onehot0(ref_route[5:3]))
    else $error("positive reference drives several sources");
  AST_NEG_ONE: assert property ($onehot0(ref_route[2:0]))
    else $error("negative reference drives several sources");
  AST_RESET_ROUTE: assert property ($rose(rst_n) |=>
    ref_route == 6'h24 && amp_route == 4'h4)
    else $error("routes wrong after reset");
  AST_PIPE: assert property (raw_in |-> ##2 cal_valid)
    else $error("result not two cycles after sample");
  AST_RESULT_HOLD: assert property ($changed(cal_result) |-> cal_valid)
    else $error("result moved without valid");
  AST_SPARE_ZERO: assert property (spare_rd |-> hrdata == 32'h0)
    else $error("spare location read nonzero");
  AST_GAIN_ONE: assert property ($onehot0(amp_route[2:0]))
    else $error("several gains selected");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule
bind adc_ref_cal_gain_regs adc_ref_cal_gain_regs_chk chk (
  .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .raw_valid(raw_valid), .cal_valid(cal_valid),
  .cal_result(cal_result), .ref_route(ref_route), .amp_route(amp_route));
`default_nettype wire

// *** tb/test_adc_ref_cal_gain_regs.sv ***
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_adc_ref_cal_gain_regs;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic raw_valid = 1'b0;
  logic [23:0] raw_sample = 24'h0;
  wire logic hready;
  wire logic hresp;
  wire logic cal_valid;
  wire logic [31:0] hrdata;
  wire logic [23:0] cal_result;
  cal_regs_pkg::ref_route_t ref_route;
  cal_regs_pkg::amp_route_t amp_route;
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] q;
  always #12.5 clock = ~clock;
  adc_ref_cal_gain_regs dut (.clock(clock), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .raw_valid(raw_valid), .raw_sample(raw_sample),
    .cal_valid(cal_valid), .cal_result(cal_result),
    .ref_route(ref_route), .amp_route(amp_route));
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask
  // Idle edge after a write: a read right behind it would already see the new value
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge clock);
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic t_reset();
    repeat (2) @(posedge clock);
    `CHK(ref_route, 6'h24)
    `CHK(amp_route, 4'h4)
    for (int i = 0; i < 11; i++) begin
      rd(32'h18 + 4 * i);
      `CHK(q, i == 0 ? 32'h5 : i == 6 ? 32'h40 : 32'h0)
    end
    $display("test reset done");
  endtask
  task automatic t_ref();
    for (int i = 0; i < 4; i++) begin
      wr(32'h18, {28'h0, i[1:0], i[1:0]});
      rd(32'h18);
      `CHK(q, {28'h0, i[1:0], i[1:0]})
      `CHK(ref_route[5:3], i == 0 ? 3'h0 : 3'h1 << (3 - i))
      `CHK(ref_route[2:0], i == 0 ? 3'h0 : 3'h1 << (3 - i))
    end
    wr(32'h18, 32'h5);
    $display("test reference done");
  endtask
  task automatic t_amp();
    logic [7:0] code [5] = '{8'h00, 8'h06, 8'h07, 8'h80, 8'h03};
    logic [3:0] exp [5] = '{4'h4, 4'h2, 4'h1, 4'hC, 4'h0};
    for (int i = 0; i < 5; i++) begin
      wr(32'h40, {24'h0, code[i]});
      rd(32'h40);
      `CHK(q, {24'h0, code[i]})
      `CHK(amp_route, exp[i])
    end
    wr(32'h40, 32'h0);
    $display("test amplifier done");
  endtask
  task automatic t_spare();
    for (int i = 0; i < 3; i++) begin
      wr(32'h34 + 4 * i, 32'hFF);
      rd(32'h34 + 4 * i);
      `CHK(q, 32'h0)
    end
    $display("test spare done");
  endtask
  task automatic cal(input logic [23:0] off, input logic [23:0] fs,
    input logic [23:0] raw);
    longint e;
    for (int b = 0; b < 3; b++) begin
      wr(32'h1C + 4 * b, {24'h0, off[8 * b +: 8]});
      wr(32'h28 + 4 * b, {24'h0, fs[8 * b +: 8]});
    end
    e = longint'($signed(raw)) - longint'($signed(off));
    e = (e * longint'(fs)) >>> 22;
    if (e > 64'sh7FFFFF) e = 64'sh7FFFFF;
    if (e < -64'sh800000) e = -64'sh800000;
    raw_sample <= raw;
    raw_valid <= 1'b1;
    @(posedge clock);
    raw_valid <= 1'b0;
    for (int k = 0; k < 6 && cal_valid !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    `CHK(cal_valid, 1'b1)
    `CHK(cal_result, e[23:0])
    @(posedge clock);
  endtask
  task automatic t_sw();
    wr(32'h50, 32'h00000123);
    repeat (2) @(posedge clock);
    rd(32'h50);
    `CHK(q, 32'h00000123)
    rd(32'h54);
    `CHK(q, 32'h00000120)
    rd(32'h58);
    `CHK(q, 32'h00000000)
    $display("test software sample done");
  endtask
  task automatic t_cal();
    cal(24'hFFFFFB, 24'h400000, 24'h000064);
    cal(24'h00000A, 24'h200000, 24'h0003E8);
    cal(24'h000000, 24'h800000, 24'h000010);
    cal(24'h000000, 24'hFFFFFF, 24'h7FFFFF);
    cal(24'h000003, 24'h400000, 24'hFFFFFE);
    $display("test calibration done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_ref();
    t_amp();
    t_spare();
    t_cal();
    t_sw();
    wrap_up();
  end
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
